// File: tb_tfl_indirect.sv
// self-checking bench for the link and refill mark access
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("BAD %0t mismatch", $time); end end
module tb_tfl_indirect;
   logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dma_refill_req;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic [7:0]  dma_channel = 8'hff;
   logic [9:0]  dma_blocks_left = 10'h005, fifo_block = 10'h3ff, dma_refill_mark, fifo_next_block;
   int          failures = 0, compares = 0;
   always #25 clock = ~clock;
   tfl_indirect uut (.*);
   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic acc(input bit w, input logic [11:0] a, input logic [15:0] v, input bit c);
      @(posedge clock);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
      @(posedge clock);
      {reg_wr, reg_rd} <= 2'b00;
      #1 d = reg_rdata;
      if (c) `CHK(d, v)
   endtask
   // store, poll, clear the data register, fetch back
   task automatic seq(input logic [11:0] a, input logic [15:0] i, v);
      acc(1'b1, a + 12'h004, v, 1'b0);
      acc(1'b1, a, i, 1'b0);
      d = 16'h8000;
      for (int n = 0; n < 8 && d[15] === 1'b1; n++) acc(1'b0, a, i, 1'b0);
      `CHK(d, i)
      acc(1'b1, a + 12'h004, 16'h0000, 1'b0);
      acc(1'b1, a, i | 16'h4000, 1'b0);
      acc(1'b0, a, i | 16'hc000, 1'b1);
      for (int n = 0; n < 8 && d[15] === 1'b1; n++) acc(1'b0, a, i, 1'b0);
      `CHK(d, i | 16'h4000)
      acc(1'b0, a + 12'h004, v, 1'b1);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 3; i++) acc(1'b0, 12'h990 + 12'(i * 8), 16'h0000, 1'b1);
      $display("reset test done");
      seq(12'h990, 16'h03ff, 16'h0001);
      `CHK(fifo_next_block, 10'h001)
      seq(12'h9a0, 16'h00ff, 16'h0005);
      `CHK(dma_refill_req, 1'b1)
      `CHK(dma_refill_mark, 10'h005)
      @(posedge clock);
      dma_blocks_left <= 10'h006;
      @(posedge clock);
      #1 `CHK(dma_refill_req, 1'b0)
      $display("access test done");
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge clock);
      failures++;
      report_and_stop();
   end
endmodule

// File: tfl_defines.vh
// register map, field layout and timing constants for the transmit fifo link / refill mark indirect access
`ifndef TFL_DEFINES_VH
`define TFL_DEFINES_VH

// ==========================================
// register offsets
`define TFL_ADDR_W            12
`define TFL_OFS_LINK_SEL      12'h990
`define TFL_OFS_LINK_DATA     12'h994
`define TFL_OFS_MARK_SEL      12'h9a0
`define TFL_OFS_MARK_DATA     12'h9a4

// ==========================================
// field layout
`define TFL_BLOCK_INDEX_W     10
`define TFL_CHANNEL_INDEX_W   8
`define TFL_NEXT_BLOCK_W      10
`define TFL_REFILL_MARK_W     10
`define TFL_DIR_BIT           14
`define TFL_BUSY_BIT          15
`define TFL_LINK_DEPTH        1024
`define TFL_MARK_DEPTH        256

// ==========================================
// reset values
`define TFL_SEL_RESET         16'h0000

// ==========================================
// timing: ram access takes this many cycles of busy
`define TFL_ACCESS_CYCLES     2'h2

`endif

// File: tfl_indirect.v
// indirect access to the transmit fifo next-block link ram and per-channel refill mark ram
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - The link select register holds a 10-bit block index in bits 0 to 9 choosing one of 1024 link entries.
// - Writing link select with direction one fetches the indexed link entry into the data register under busy.
// - Writing link select with direction zero stores the link data register into the indexed entry under busy.
// - Bit 15 of each select register is a read-only busy flag, high while an indirect access is in progress.
// - The link data register carries a 10-bit next-block field in bits 0 to 9.
// - The refill mark select register holds an 8-bit channel index in bits 0 to 7 for 256 channels.
// - Writing refill mark select with direction one reads the indexed mark into the mark data register under busy.
// - Writing refill mark select with direction zero stores the mark data register into the indexed entry under busy.
// - The 10-bit refill mark is the count of blocks left at which the transmit dma fetches more data.
// - Both select registers reset to all zeros.
`include "tfl_defines.vh"

module tfl_indirect (
   // clock and reset
   input  wire                            clock,
   input  wire                            sys_rst,
   // register port
   input  wire [`TFL_ADDR_W-1:0]          reg_addr,
   input  wire [15:0]                     reg_wdata,
   input  wire                            reg_wr,
   input  wire                            reg_rd,
   output reg  [15:0]                     reg_rdata,
   // refill mark lookup for the transmit dma
   input  wire [`TFL_CHANNEL_INDEX_W-1:0] dma_channel,
   input  wire [`TFL_REFILL_MARK_W-1:0]   dma_blocks_left,
   output reg  [`TFL_REFILL_MARK_W-1:0]   dma_refill_mark,
   output reg                             dma_refill_req,
   // next-block lookup for the fifo
   input  wire [`TFL_BLOCK_INDEX_W-1:0]   fifo_block,
   output reg  [`TFL_NEXT_BLOCK_W-1:0]    fifo_next_block
);

   // ==========================================
   // access sequencer states and constants
   localparam       ST_IDLE  = 1'b0;
   localparam       ST_BUSY  = 1'b1;
   localparam [1:0] CNT_ONE  = 2'h1;
   localparam [1:0] CNT_ZERO = 2'h0;

   // ==========================================
   // helper functions
   // exact match of a register offset
   function addr_hit;
      input [`TFL_ADDR_W-1:0] addr;
      input [`TFL_ADDR_W-1:0] ofs;
      begin
         addr_hit = (addr == ofs);
      end
   endfunction

   // last busy cycle of an access, when the ram is touched
   function access_last;
      input       state;
      input [1:0] cnt;
      begin
         access_last = (state == ST_BUSY) && (cnt == CNT_ONE);
      end
   endfunction

   // refill once blocks left fall to the mark; a zero mark never fires
   function refill_due;
      input [`TFL_REFILL_MARK_W-1:0] mark;
      input [`TFL_REFILL_MARK_W-1:0] left;
      begin
         refill_due = (mark != {`TFL_REFILL_MARK_W{1'b0}}) && (left <= mark);
      end
   endfunction

   // ==========================================
   // storage
   reg [`TFL_NEXT_BLOCK_W-1:0]    link_ram [0:`TFL_LINK_DEPTH-1];
   reg [`TFL_REFILL_MARK_W-1:0]   mark_ram [0:`TFL_MARK_DEPTH-1];

   // link side registers and next values
   reg                            link_state_r;
   reg                            link_state_nxt;
   reg [`TFL_BLOCK_INDEX_W-1:0]   link_index_r;
   reg [`TFL_BLOCK_INDEX_W-1:0]   link_index_nxt;
   reg                            link_dir_r;
   reg                            link_dir_nxt;
   reg [1:0]                      link_cnt_r;
   reg [1:0]                      link_cnt_nxt;
   reg [`TFL_NEXT_BLOCK_W-1:0]    link_data_r;
   reg [`TFL_NEXT_BLOCK_W-1:0]    link_data_nxt;

   // refill mark side registers and next values
   reg                            mark_state_r;
   reg                            mark_state_nxt;
   reg [`TFL_CHANNEL_INDEX_W-1:0] mark_index_r;
   reg [`TFL_CHANNEL_INDEX_W-1:0] mark_index_nxt;
   reg                            mark_dir_r;
   reg                            mark_dir_nxt;
   reg [1:0]                      mark_cnt_r;
   reg [1:0]                      mark_cnt_nxt;
   reg [`TFL_REFILL_MARK_W-1:0]   mark_data_r;
   reg [`TFL_REFILL_MARK_W-1:0]   mark_data_nxt;

   // read data before its register
   reg [15:0]                     rdata_nxt;

   // decoded strobes and access status
   wire                           wr_link_sel;
   wire                           wr_link_data;
   wire                           wr_mark_sel;
   wire                           wr_mark_data;
   wire                           link_busy;
   wire                           mark_busy;
   wire                           link_last;
   wire                           mark_last;
   wire                           link_ram_we;
   wire                           mark_ram_we;

   assign wr_link_sel  = reg_wr && addr_hit(reg_addr, `TFL_OFS_LINK_SEL);
   assign wr_link_data = reg_wr && addr_hit(reg_addr, `TFL_OFS_LINK_DATA);
   assign wr_mark_sel  = reg_wr && addr_hit(reg_addr, `TFL_OFS_MARK_SEL);
   assign wr_mark_data = reg_wr && addr_hit(reg_addr, `TFL_OFS_MARK_DATA);

   assign link_busy    = (link_state_r == ST_BUSY);
   assign mark_busy    = (mark_state_r == ST_BUSY);
   assign link_last    = access_last(link_state_r, link_cnt_r);
   assign mark_last    = access_last(mark_state_r, mark_cnt_r);
   assign link_ram_we  = link_last && !link_dir_r && !sys_rst;
   assign mark_ram_we  = mark_last && !mark_dir_r && !sys_rst;

   // ==========================================
   // link ram indirect access
   always @* begin
      link_state_nxt = link_state_r;
      link_index_nxt = link_index_r;
      link_dir_nxt   = link_dir_r;
      link_cnt_nxt   = link_cnt_r;
      link_data_nxt  = link_data_r;
      case (link_state_r)
         ST_IDLE: begin
            if (wr_link_sel) begin
               link_index_nxt = reg_wdata[`TFL_BLOCK_INDEX_W-1:0];
               link_dir_nxt   = reg_wdata[`TFL_DIR_BIT];
               link_cnt_nxt   = `TFL_ACCESS_CYCLES;
               link_state_nxt = ST_BUSY;
            end
            if (wr_link_data) begin
               link_data_nxt = reg_wdata[`TFL_NEXT_BLOCK_W-1:0];
            end
         end
         ST_BUSY: begin
            // writes while busy are dropped so the access keeps stable operands
            link_cnt_nxt = link_cnt_r - CNT_ONE;
            if (link_last) begin
               link_state_nxt = ST_IDLE;
               if (link_dir_r) begin
                  link_data_nxt = link_ram[link_index_r];
               end
            end
         end
         default: begin
            link_state_nxt = ST_IDLE;
            link_cnt_nxt   = CNT_ZERO;
         end
      endcase
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         link_state_r <= ST_IDLE;
         link_index_r <= {`TFL_BLOCK_INDEX_W{1'b0}};
         link_dir_r   <= 1'b0;
         link_cnt_r   <= CNT_ZERO;
         link_data_r  <= {`TFL_NEXT_BLOCK_W{1'b0}};
      end else begin
         link_state_r <= link_state_nxt;
         link_index_r <= link_index_nxt;
         link_dir_r   <= link_dir_nxt;
         link_cnt_r   <= link_cnt_nxt;
         link_data_r  <= link_data_nxt;
      end
   end

   // store lands on the last busy cycle
   always @(posedge clock) begin
      if (link_ram_we) begin
         link_ram[link_index_r] <= link_data_r;
      end
   end

   // ==========================================
   // refill mark ram indirect access
   always @* begin
      mark_state_nxt = mark_state_r;
      mark_index_nxt = mark_index_r;
      mark_dir_nxt   = mark_dir_r;
      mark_cnt_nxt   = mark_cnt_r;
      mark_data_nxt  = mark_data_r;
      case (mark_state_r)
         ST_IDLE: begin
            if (wr_mark_sel) begin
               mark_index_nxt = reg_wdata[`TFL_CHANNEL_INDEX_W-1:0];
               mark_dir_nxt   = reg_wdata[`TFL_DIR_BIT];
               mark_cnt_nxt   = `TFL_ACCESS_CYCLES;
               mark_state_nxt = ST_BUSY;
            end
            if (wr_mark_data) begin
               mark_data_nxt = reg_wdata[`TFL_REFILL_MARK_W-1:0];
            end
         end
         ST_BUSY: begin
            // writes while busy are dropped so the access keeps stable operands
            mark_cnt_nxt = mark_cnt_r - CNT_ONE;
            if (mark_last) begin
               mark_state_nxt = ST_IDLE;
               if (mark_dir_r) begin
                  mark_data_nxt = mark_ram[mark_index_r];
               end
            end
         end
         default: begin
            mark_state_nxt = ST_IDLE;
            mark_cnt_nxt   = CNT_ZERO;
         end
      endcase
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         mark_state_r <= ST_IDLE;
         mark_index_r <= {`TFL_CHANNEL_INDEX_W{1'b0}};
         mark_dir_r   <= 1'b0;
         mark_cnt_r   <= CNT_ZERO;
         mark_data_r  <= {`TFL_REFILL_MARK_W{1'b0}};
      end else begin
         mark_state_r <= mark_state_nxt;
         mark_index_r <= mark_index_nxt;
         mark_dir_r   <= mark_dir_nxt;
         mark_cnt_r   <= mark_cnt_nxt;
         mark_data_r  <= mark_data_nxt;
      end
   end

   // store lands on the last busy cycle
   always @(posedge clock) begin
      if (mark_ram_we) begin
         mark_ram[mark_index_r] <= mark_data_r;
      end
   end

   // ==========================================
   // consumers: next-block lookup and refill decision
   always @(posedge clock) begin
      if (sys_rst) begin
         fifo_next_block <= {`TFL_NEXT_BLOCK_W{1'b0}};
         dma_refill_mark <= {`TFL_REFILL_MARK_W{1'b0}};
         dma_refill_req  <= 1'b0;
      end else begin
         fifo_next_block <= link_ram[fifo_block];
         dma_refill_mark <= mark_ram[dma_channel];
         dma_refill_req  <= refill_due(mark_ram[dma_channel], dma_blocks_left);
      end
   end

   // ==========================================
   // register read mux; unused bits and idle cycles read zero
   always @* begin
      rdata_nxt = 16'h0000;
      if (reg_rd) begin
         if (addr_hit(reg_addr, `TFL_OFS_LINK_SEL)) begin
            rdata_nxt = {link_busy, link_dir_r, 4'h0, link_index_r};
         end else if (addr_hit(reg_addr, `TFL_OFS_LINK_DATA)) begin
            rdata_nxt = {6'h00, link_data_r};
         end else if (addr_hit(reg_addr, `TFL_OFS_MARK_SEL)) begin
            rdata_nxt = {mark_busy, mark_dir_r, 6'h00, mark_index_r};
         end else if (addr_hit(reg_addr, `TFL_OFS_MARK_DATA)) begin
            rdata_nxt = {6'h00, mark_data_r};
         end else begin
            rdata_nxt = 16'h0000;
         end
      end
   end

   // read data stands one cycle after the strobe
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= rdata_nxt;
      end
   end

endmodule

// File: tfl_indirect_chk.sv
// assertions on the indirect access register port
`timescale 1ns/1ps
module tfl_chk (
   // register port
   input logic        clock,
   input logic        sys_rst,
   input logic [11:0] reg_addr,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [15:0] reg_rdata
);
   wire lw = reg_wr && reg_addr == 12'h990, lr = reg_rd && reg_addr == 12'h990;
   wire mw = reg_wr && reg_addr == 12'h9a0, mr = reg_rd && reg_addr == 12'h9a0;
   wire ld = reg_rd && reg_addr == 12'h994;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata idle");
   a_lsel_gap: assert property ($past(lr) |-> reg_rdata[13:10] == 4'h0) else $error("lsel");
   a_msel_gap: assert property ($past(mr) |-> reg_rdata[13:8] == 6'h00) else $error("msel");
   a_ldata_width: assert property ($past(ld) |-> reg_rdata[15:10] == 6'h00) else $error("ldata");
   a_link_busy: assert property (lw ##2 lr |=> reg_rdata[15]) else $error("lbusy");
   a_mark_busy: assert property (mw ##2 mr |=> reg_rdata[15]) else $error("mbusy");
   a_link_done: assert property (lw ##2 lr ##2 lr |=> !reg_rdata[15]) else $error("ldone");
   a_mark_done: assert property (mw ##2 mr ##2 mr |=> !reg_rdata[15]) else $error("mdone");
endmodule
bind tfl_indirect tfl_chk chk (.*);
